// ==== rtl/psd_deadband.sv ====
`timescale 1ns/1ps
`default_nettype none
module psd_deadband #(
  parameter int unsigned CNT_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // timing
  input wire logic tick,
  input wire logic freeze,
  // waveform
  input wire logic level_in,
  input wire logic [CNT_W-1:0] delay,
  output logic level_out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
  } psd_db_s;

  psd_db_s q, d;

  always_comb begin
    d = q;
    if (!freeze) begin
      if (!level_in) begin
        d.cnt = '0;
        d.out = 1'b0;
      end else if (!q.out) begin
        if (q.cnt == delay) begin
          d.out = 1'b1;
        end else if (tick) begin
          d.cnt = CNT_W'(q.cnt + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.out;

  // fall to inactive is never delayed unless frozen
  db_fall_fast_a: assert property (@(posedge clk) disable iff (!rstn)
    (!freeze && !level_in) |=> !level_out)
    else $error("dead band delayed a falling edge");
endmodule
`default_nettype wire

// ==== rtl/psd_map.svh ====
`ifndef PSD_MAP_SVH
`define PSD_MAP_SVH

// register byte offsets
`define PSD_OFF_CTRL 8'h00
`define PSD_OFF_PERIOD 8'h04
`define PSD_OFF_DUTY 8'h08
`define PSD_OFF_SHUT 8'h0C
`define PSD_OFF_DEAD 8'h10
`define PSD_OFF_FLAG 8'h14

// pwm_control_register fields
`define PSD_CTRL_POL_A 0
`define PSD_CTRL_POL_B 1
`define PSD_CTRL_MODE 2
`define PSD_CTRL_EN 3
`define PSD_CTRL_DRV_A 4
`define PSD_CTRL_DRV_B 5

// auto_shutdown_control fields
`define PSD_SD_STAT 7
`define PSD_SD_SRC_LSB 4
`define PSD_SD_PSSA_LSB 2
`define PSD_SD_PSSB_LSB 0

// dead_band_control fields
`define PSD_DB_RESTART 7

// flag register fields
`define PSD_FLG_PTF 0
`define PSD_FLG_RUN 1
`define PSD_FLG_SDACT 2
`define PSD_FLG_COND 3

// reset values
`define PSD_RST_BYTE 8'h00

// one instruction cycle is four oscillator periods
`define PSD_ICYC_LAST 2'h3

`endif

// ==== rtl/psd_pkg.sv ====
package psd_pkg;

  typedef enum logic [2:0] {
    PSD_SRC_OFF0 = 3'b000,
    PSD_SRC_CMP0 = 3'b001,
    PSD_SRC_OFF1 = 3'b010,
    PSD_SRC_CMP1 = 3'b011,
    PSD_SRC_PIN = 3'b100,
    PSD_SRC_PINCMP = 3'b101,
    PSD_SRC_RSV6 = 3'b110,
    PSD_SRC_RSV7 = 3'b111
  } psd_src_e;

  typedef enum logic {
    PSD_MODE_SINGLE = 1'b0,
    PSD_MODE_HALF = 1'b1
  } psd_mode_e;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [1:0] pol;
    psd_mode_e mode;
    logic en;
    logic drv_a;
    logic drv_b;
    logic [7:0] period;
    logic [7:0] duty;
    logic [7:0] duty_lat;
    logic sd_status;
    psd_src_e sd_src;
    logic [1:0] pssa;
    logic [1:0] pssb;
    logic restart_en;
    logic [6:0] dead;
    logic ptf;
    logic [1:0] presc;
    logic [7:0] timer;
    logic running;
    logic sd_hold;
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
  } psd_top_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } psd_sync_s;

endpackage

// ==== rtl/psd_pwm_top.sv ====
// Operation
// - two polarity bits pick active-high or active-low per output pin.
// - period flag sets at each period start, first one starting period two.
// - sleep freezes timer and module state; outputs keep their level.
// - three source bits pick comparator, low interrupt pin, both, or none.
// - firmware writing one to the shutdown status bit causes shutdown.
// - status bit reads one while shutdown lasts; after it clears, outputs stay held until the next period start.
// - status stays set until firmware or auto-restart clears it.
// - shutdown forces enabled outputs to their shutdown states at once.
// - per-output two-bit state: drive low, drive high, or tri-state.
// - shutdown is level based and persists while the level stays.
// - status bit writes are ignored while the condition is active.
// - after restart the waveform resumes at the next period start.
// - with auto-restart, hardware clears status once the condition goes.
// - in half-bridge mode dead band delays only inactive-to-active edges.
// - seven-bit dead band count in instruction cycles of four clocks.
// - after reset all pin drivers are off until configured.
// - without auto-restart firmware must clear status to restart.
// - dead band longer than duty keeps that output inactive all cycle.
// - half-bridge drives pwm on output a and its complement on b.
`include "psd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module psd_pwm_top
  import psd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shutdown sources and power state
  input wire logic ext_int_n,
  input wire logic cmp_level,
  input wire logic sleep,
  // output pins
  output logic pwm_out_a,
  output logic pwm_out_a_oe,
  output logic pwm_out_b,
  output logic pwm_out_b_oe
);
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_PERIOD = 3'h1;
  localparam logic [2:0] IDX_DUTY = 3'h2;
  localparam logic [2:0] IDX_SHUT = 3'h3;
  localparam logic [2:0] IDX_DEAD = 3'h4;
  localparam logic [2:0] IDX_FLAG = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  psd_top_s q, d;

  logic pin_high_s;
  logic cmp_s;
  logic bus_req;
  logic wr_fire;
  logic [2:0] req_idx;
  logic [7:0] wbyte;
  logic cond;
  logic fw_set;
  logic fw_clr;
  logic tick;
  logic pstart;
  logic raw;
  logic sd_active;
  logic [1:0] db_in;
  logic [1:0] db_out;
  logic [6:0] db_delay;

  // word aligned decode; low address bits are ignored
  function automatic logic [2:0] reg_sel(input logic [7:0] adr);
    logic [7:0] a;
    a = {adr[7:2], 2'b00};
    if (a == `PSD_OFF_CTRL) begin
      reg_sel = IDX_CTRL;
    end else if (a == `PSD_OFF_PERIOD) begin
      reg_sel = IDX_PERIOD;
    end else if (a == `PSD_OFF_DUTY) begin
      reg_sel = IDX_DUTY;
    end else if (a == `PSD_OFF_SHUT) begin
      reg_sel = IDX_SHUT;
    end else if (a == `PSD_OFF_DEAD) begin
      reg_sel = IDX_DEAD;
    end else if (a == `PSD_OFF_FLAG) begin
      reg_sel = IDX_FLAG;
    end else begin
      reg_sel = IDX_NONE;
    end
  endfunction

  // pin level: shutdown states are absolute, the waveform follows polarity
  function automatic logic out_level(input logic sd, input logic [1:0] pss,
                                     input logic lvl, input logic pol);
    if (sd) begin
      out_level = pss[0] & ~pss[1];
    end else begin
      out_level = lvl ^ pol;
    end
  endfunction

  function automatic logic out_enable(input logic sd, input logic [1:0] pss,
                                      input logic drv);
    out_enable = drv & ~(sd & pss[1]);
  endfunction

  // pins pass four flops; the interrupt pin idles high
  psd_sync #(
    .RESET_VAL(1'b1)
  ) u_sync_int (
    .clk(clk),
    .rstn(rstn),
    .pin(ext_int_n),
    .level(pin_high_s)
  );

  psd_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_cmp (
    .clk(clk),
    .rstn(rstn),
    .pin(cmp_level),
    .level(cmp_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_db
      psd_deadband #(
        .CNT_W(7)
      ) u_db (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .freeze(sleep),
        .level_in(db_in[gi]),
        .delay(db_delay),
        .level_out(db_out[gi])
      );
    end
  endgenerate

  always_comb begin
    d = q;
    bus_req = wb_cyc_i & wb_stb_i;
    req_idx = reg_sel(wb_adr_i);
    // writes land on the edge that the master sees ack
    wr_fire = bus_req & wb_we_i & q.ack & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];

    case (q.sd_src)
      PSD_SRC_CMP0, PSD_SRC_CMP1: begin
        cond = cmp_s;
      end
      PSD_SRC_PIN: begin
        cond = ~pin_high_s;
      end
      PSD_SRC_PINCMP, PSD_SRC_RSV6, PSD_SRC_RSV7: begin
        cond = ~pin_high_s | cmp_s;
      end
      default: begin
        cond = 1'b0;
      end
    endcase

    fw_set = wr_fire & (req_idx == IDX_SHUT) & wbyte[`PSD_SD_STAT];
    fw_clr = wr_fire & (req_idx == IDX_SHUT) & ~wbyte[`PSD_SD_STAT] & ~cond;

    tick = q.en & (q.presc == `PSD_ICYC_LAST);
    pstart = tick & (q.timer == q.period);
    raw = q.running & (q.timer < q.duty_lat);
    // live condition forces outputs without waiting for the flag
    sd_active = cond | q.sd_status | q.sd_hold;

    db_in[0] = raw;
    if (q.mode == PSD_MODE_HALF) begin
      db_in[1] = q.running & ~raw;
      db_delay = q.dead;
    end else begin
      db_in[1] = raw;
      db_delay = 7'h00;
    end

    // bus answer one cycle after the request is seen
    d.ack = bus_req & ~q.ack;
    if (bus_req & ~q.ack) begin
      d.rdat = 32'h0000_0000;
      if (req_idx == IDX_CTRL) begin
        d.rdat[7:0] = {2'b00, q.drv_b, q.drv_a, q.en, q.mode, q.pol};
      end else if (req_idx == IDX_PERIOD) begin
        d.rdat[7:0] = q.period;
      end else if (req_idx == IDX_DUTY) begin
        d.rdat[7:0] = q.duty;
      end else if (req_idx == IDX_SHUT) begin
        d.rdat[7:0] = {q.sd_status, q.sd_src, q.pssa, q.pssb};
      end else if (req_idx == IDX_DEAD) begin
        d.rdat[7:0] = {q.restart_en, q.dead};
      end else if (req_idx == IDX_FLAG) begin
        d.rdat[`PSD_FLG_PTF] = q.ptf;
        d.rdat[`PSD_FLG_RUN] = q.running;
        d.rdat[`PSD_FLG_SDACT] = sd_active;
        d.rdat[`PSD_FLG_COND] = cond;
      end
    end

    if (wr_fire) begin
      if (req_idx == IDX_CTRL) begin
        d.pol = wbyte[`PSD_CTRL_POL_B:`PSD_CTRL_POL_A];
        d.mode = psd_mode_e'(wbyte[`PSD_CTRL_MODE]);
        d.en = wbyte[`PSD_CTRL_EN];
        d.drv_a = wbyte[`PSD_CTRL_DRV_A];
        d.drv_b = wbyte[`PSD_CTRL_DRV_B];
      end else if (req_idx == IDX_PERIOD) begin
        d.period = wbyte;
      end else if (req_idx == IDX_DUTY) begin
        d.duty = wbyte;
      end else if (req_idx == IDX_SHUT) begin
        d.sd_src = psd_src_e'(wbyte[`PSD_SD_SRC_LSB+2:`PSD_SD_SRC_LSB]);
        d.pssa = wbyte[`PSD_SD_PSSA_LSB+1:`PSD_SD_PSSA_LSB];
        d.pssb = wbyte[`PSD_SD_PSSB_LSB+1:`PSD_SD_PSSB_LSB];
      end else if (req_idx == IDX_DEAD) begin
        d.restart_en = wbyte[`PSD_DB_RESTART];
        d.dead = wbyte[6:0];
      end else if (req_idx == IDX_FLAG) begin
        if (wbyte[`PSD_FLG_PTF]) begin
          d.ptf = 1'b0;
        end
      end
    end

    // sleep freezes everything but the register file
    if (!sleep) begin
      if (!q.en) begin
        d.presc = 2'h0;
        d.timer = 8'h00;
      end else begin
        d.presc = 2'(q.presc + 2'h1);
        if (pstart) begin
          d.timer = 8'h00;
          d.duty_lat = q.duty;
        end else if (tick) begin
          d.timer = 8'(q.timer + 8'h01);
        end
      end
      // waveform only begins on a fresh period
      d.running = q.en & (q.running | pstart);

      // period flag, set wins over clear
      if (pstart) begin
        d.ptf = 1'b1;
      end

      if (cond | fw_set) begin
        d.sd_status = 1'b1;
      end else if (q.restart_en & q.sd_status) begin
        d.sd_status = 1'b0;
      end else if (fw_clr) begin
        d.sd_status = 1'b0;
      end

      // hold shutdown states until the next period start
      if (q.sd_status | cond) begin
        d.sd_hold = 1'b1;
      end else if (pstart) begin
        d.sd_hold = 1'b0;
      end

      d.out_a = out_level(sd_active, q.pssa, db_out[0], q.pol[0]);
      d.oe_a = out_enable(sd_active, q.pssa, q.drv_a);
      d.out_b = out_level(sd_active, q.pssb, db_out[1], q.pol[1]);
      d.oe_b = out_enable(sd_active, q.pssb, q.drv_b);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign pwm_out_a = q.out_a;
  assign pwm_out_a_oe = q.oe_a;
  assign pwm_out_b = q.out_b;
  assign pwm_out_b_oe = q.oe_b;

  bus_ack_once_a: assert property (@(posedge clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  drv_off_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && !q.drv_a && !q.drv_b) [*2] |-> (!pwm_out_a_oe && !pwm_out_b_oe))
    else $error("pin driven while driver disabled");

  pol_a_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && !sd_active && !q.running && !db_out[0]) |=> (pwm_out_a == $past(q.pol[0])))
    else $error("idle level does not match polarity");

  ptf_period_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && pstart) |=> (q.ptf && q.timer == 8'h00))
    else $error("period flag missed at period start");

  sleep_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    sleep |=> ($stable(q.timer) && $stable(pwm_out_a) && $stable(pwm_out_b_oe)))
    else $error("state changed during sleep");

  src_off_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && !q.sd_status && !fw_set && q.sd_src inside {PSD_SRC_OFF0, PSD_SRC_OFF1}) |=> !q.sd_status)
    else $error("shutdown with sources disabled");

  fw_event_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && fw_set) |=> q.sd_status)
    else $error("firmware shutdown not taken");

  stat_persist_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && cond) |=> (q.sd_status && q.sd_hold))
    else $error("status cleared while condition active");

  tri_b_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && sd_active && q.pssb[1]) |=> !pwm_out_b_oe)
    else $error("output b not tri-stated in shutdown");

  drive_b_high_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && sd_active && q.pssb == 2'b01 && q.drv_b) |=> (pwm_out_b && pwm_out_b_oe))
    else $error("output b not forced high in shutdown");

  auto_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && q.restart_en && q.sd_status && !cond && !fw_set) |=> !q.sd_status)
    else $error("auto-restart did not clear status");

  resume_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sleep && q.sd_hold && !pstart) |=> q.sd_hold)
    else $error("shutdown released before period boundary");
endmodule
`default_nettype wire

// ==== rtl/psd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psd_sync
  import psd_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin side
  input wire logic pin,
  // clock side
  output logic level
);
  psd_sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a change counts only once two late stages agree
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule
`default_nettype wire

// ==== tb/psd_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psd_bridge_model (
  // design pins
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // bench commands
  input wire logic fault_req,
  input wire logic cmp_req,
  // resolved lines
  output logic pin_a,
  output logic pin_b,
  output logic ext_int_n,
  output logic cmp_level
);
  // pull-downs keep both switches off while a pin floats
  assign pin_a = a_oe ? a_out : 1'h0;
  assign pin_b = b_oe ? b_out : 1'h0;
  // open-drain fault line with pull-up, low while the fault lasts
  assign ext_int_n = fault_req ? 1'h0 : 1'h1;
  assign cmp_level = cmp_req;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psd_map.svh"
module tb
  import psd_pkg::*;
;
  logic clk, rstn, cyc, stb, we, sleep, fault_req, cmp_req;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic ack, a_out, a_oe, b_out, b_oe, pin_a, pin_b, ext_int_n, cmp_level;
  int errors, compares, cycles;

  psd_pwm_top psd_pwm_top_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_int_n(ext_int_n), .cmp_level(cmp_level), .sleep(sleep), .pwm_out_a(a_out),
    .pwm_out_a_oe(a_oe), .pwm_out_b(b_out), .pwm_out_b_oe(b_oe));
  psd_bridge_model psd_bridge_model_inst (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .fault_req(fault_req), .cmp_req(cmp_req), .pin_a(pin_a), .pin_b(pin_b),
    .ext_int_n(ext_int_n), .cmp_level(cmp_level));

  always #5 clk = ~clk;

  task automatic end_of_test;
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      end_of_test;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // only the cycle ceiling ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'h0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wait_flag;
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (q[`PSD_FLG_PTF] !== 1'h1 && n < 40) begin
      wb(1'h0, `PSD_OFF_FLAG, 8'h00, q);
      n++;
    end
    chk({7'h00, q[`PSD_FLG_PTF]}, 8'h01);
  endtask

  task automatic start(input logic [1:0] pol);
    wr(`PSD_OFF_PERIOD, 8'h03);
    wr(`PSD_OFF_DUTY, 8'h02);
    wr(`PSD_OFF_CTRL, {4'h0, 2'h3, pol});
    wr(`PSD_OFF_FLAG, 8'h01);
    wait_flag;
    wr(`PSD_OFF_CTRL, {4'h3, 2'h3, pol});
  endtask

  task automatic t_reset;
    chk({6'h00, a_oe, b_oe}, 8'h00);
    rd_chk(`PSD_OFF_SHUT, 8'h00);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    wr(`PSD_OFF_DEAD, 8'h85);
    rd_chk(`PSD_OFF_DEAD, 8'h85);
    wr(`PSD_OFF_DEAD, 8'h00);
  endtask

  task automatic t_sources;
    logic [2:0] src;
    logic sdact;
    for (int m = 0; m < 2; m++) begin
      cmp_req <= (m == 0);
      fault_req <= (m == 1);
      idle(6);
      for (int s = 0; s < 8; s++) begin
        src = s[2:0];
        // the hold stays set while the timer is stopped, so it sticks once any source fired
        sdact = (m == 1) || (s != 0);
        wr(`PSD_OFF_SHUT, {1'h0, src, 4'h0});
        rd_chk(`PSD_OFF_FLAG, {4'h0, (m == 0) ? (src[0] | (src[2] & src[1])) : src[2], sdact, 2'h0});
      end
    end
    cmp_req <= 1'h0;
    fault_req <= 1'h0;
    idle(8);
    wr(`PSD_OFF_SHUT, 8'h00);
    rd_chk(`PSD_OFF_SHUT, 8'h00);
  endtask

  task automatic t_firmware_sd;
    start(2'h0);
    wr(`PSD_OFF_SHUT, 8'h86);
    idle(2);
    rd_chk(`PSD_OFF_SHUT, 8'h86);
    chk({6'h00, pin_a, a_oe}, 8'h03);
    chk({6'h00, pin_b, b_oe}, 8'h00);
    idle(20);
    rd_chk(`PSD_OFF_SHUT, 8'h86);
    wr(`PSD_OFF_SHUT, 8'h06);
    rd_chk(`PSD_OFF_SHUT, 8'h06);
    idle(40);
    chk({7'h00, b_oe}, 8'h01);
  endtask

  task automatic t_pin_sd;
    wr(`PSD_OFF_SHUT, 8'h41);
    fault_req <= 1'h1;
    idle(8);
    rd_chk(`PSD_OFF_SHUT, 8'hC1);
    chk({6'h00, pin_a, a_oe}, 8'h01);
    chk({6'h00, pin_b, b_oe}, 8'h03);
    wr(`PSD_OFF_SHUT, 8'h41);
    rd_chk(`PSD_OFF_SHUT, 8'hC1);
    idle(40);
    wr(`PSD_OFF_DEAD, 8'h80);
    rd_chk(`PSD_OFF_SHUT, 8'hC1);
    fault_req <= 1'h0;
    idle(10);
    rd_chk(`PSD_OFF_SHUT, 8'h41);
    idle(40);
    rd_chk(`PSD_OFF_FLAG, 8'h03);
    wr(`PSD_OFF_SHUT, 8'h00);
  endtask

  task automatic t_bridge(input logic [1:0] pol, input logic [7:0] dead, input logic seen);
    int na, nb, nboth;
    na = 0;
    nb = 0;
    nboth = 0;
    wr(`PSD_OFF_DEAD, dead);
    start(pol);
    idle(8);
    repeat (64) begin
      @(posedge clk);
      na += ((pin_a ^ pol[0]) === 1'h1);
      nb += ((pin_b ^ pol[1]) === 1'h1);
      nboth += ((pin_a ^ pol[0]) === 1'h1 && (pin_b ^ pol[1]) === 1'h1);
    end
    chk(nboth[7:0], 8'h00);
    chk({7'h00, na > 0}, {7'h00, seen});
    chk({7'h00, nb > 0}, {7'h00, seen});
  endtask

  task automatic t_sleep;
    logic ha, hb;
    sleep <= 1'h1;
    idle(2);
    ha = pin_a;
    hb = pin_b;
    idle(50);
    chk({6'h00, pin_a, pin_b}, {6'h00, ha, hb});
    sleep <= 1'h0;
    wr(`PSD_OFF_FLAG, 8'h01);
    wait_flag;
  endtask

  // a reset in mid-run must release the pins that were driven
  task automatic t_rerun_reset;
    rstn <= 1'h0;
    idle(2);
    chk({6'h00, a_oe, b_oe}, 8'h00);
    rstn <= 1'h1;
    rd_chk(`PSD_OFF_CTRL, 8'h00);
  endtask

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    sleep = 1'h0;
    fault_req = 1'h0;
    cmp_req = 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    t_reset;
    t_sources;
    t_firmware_sd;
    t_pin_sd;
    t_bridge(2'h0, 8'h01, 1'h1);
    t_sleep;
    t_bridge(2'h3, 8'h01, 1'h1);
    t_bridge(2'h0, 8'h7F, 1'h0);
    t_rerun_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
